// ==== core/tas_pkg.sv ====
// Constants and register map for the trigger arm sequencer
// Contract
// - Arm select codes: always 1, external 2, single 3, hold 4, sync 5
// - External mode arms only after a falling edge on the trigger input
// - Selecting external mode empties the trigger buffer when buffering is on
// - Single mode arms once on command, then selection becomes hold
// - Sync mode arms when output buffer empty, memory off/empty, data requested
// - Power-up and missing event select always-armed
// - Arm count only with single; zero or one acts as one
// - Count above one gives one arm per cycle, then hold after last
// - Order is arm, then trigger, then sample; arm only enables trigger
// - Multiple arming holds host bus busy until all cycles finish
// - Arm setting readback returns current selection
// - Buffer control off 0, on 1; turning on empties buffer, stops error
// - Buffering off: trigger during reading dropped, raises early error
// - Buffering on: first trigger stored, no error for any
// - After reading completes, stored trigger serves as external event
// - Buffering off after reset and after reset command
// - Buffer setting readback reports on or off
// - Reading begins only at sample event after trigger enabled
package tas_pkg;
   localparam logic [31:0] ARM_SEL_ADDR  = 32'h0000_0000;
   localparam logic [31:0] ARM_CNT_ADDR  = 32'h0000_0004;
   localparam logic [31:0] BUF_CTL_ADDR  = 32'h0000_0008;
   localparam logic [31:0] CMD_ADDR      = 32'h0000_000c;
   localparam logic [31:0] STATUS_ADDR   = 32'h0000_0010;
   localparam logic [2:0]  ARM_ALWAYS    = 3'h1;
   localparam logic [2:0]  ARM_EXT       = 3'h2;
   localparam logic [2:0]  ARM_SINGLE    = 3'h3;
   localparam logic [2:0]  ARM_HOLD      = 3'h4;
   localparam logic [2:0]  ARM_SYNC      = 3'h5;
   localparam logic [2:0]  ARM_NONE      = 3'h0;
   localparam int          CNT_W         = 32;
   localparam int          CMD_SGL_BIT   = 0;
   localparam int          CMD_RST_BIT   = 1;
   localparam int          ST_ARMED_BIT  = 0;
   localparam int          ST_PEND_BIT   = 1;
   localparam int          ST_ERR_BIT    = 2;
   localparam int          ST_BUSY_BIT   = 3;
   localparam int          ST_STORED_BIT = 4;
   localparam logic [31:0] CNT_ONE       = 32'h0000_0001;
   localparam logic [31:0] CNT_MAX       = 32'h7d2b_7500;
   typedef enum logic [1:0] {
      TAS_IDLE  = 2'b00,
      TAS_ARMED = 2'b01,
      TAS_TRIG  = 2'b10,
      TAS_READ  = 2'b11
   } tas_state_e;
endpackage

// ==== core/tas_trigger_arm.sv ====
// Trigger arm selection, external trigger buffering and APB registers
`timescale 1ns/1ns
module tas_trigger_arm (
   input  wire logic        core_clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        clk_en_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [31:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   input  wire logic        ext_trig_i,
   input  wire logic        out_buf_empty_i,
   input  wire logic        mem_off_or_empty_i,
   input  wire logic        data_request_sync_i,
   input  wire logic        trig_event_i,
   input  wire logic        sample_event_i,
   input  wire logic        reading_done_i,
   output logic             trig_enable_o,
   output logic             reading_start_o,
   output logic             ext_event_o,
   output logic             early_trigger_error_o,
   output logic             bus_hold_o,
   output logic             reading_busy_o
);
   tas_pkg::tas_state_e     state, next_state;
   logic [2:0]              arm_event_select, next_arm_event_select;
   logic [31:0]             arms_left, next_arms_left;
   logic [31:0]             arm_cnt, next_arm_cnt;
   logic                    ext_trigger_hold_ctl, next_ext_trigger_hold_ctl;
   logic                    stored, next_stored;
   logic                    err, next_err;
   logic                    pend_ext, next_pend_ext;
   logic                    sync1, sync2, sync3;
   logic [31:0]             next_prdata;
   logic                    next_pready, next_start, next_ext_ev;
   logic                    fall_pulse, wr_en, rd_en, sgl_cmd, rst_cmd, arm_now, err_set;

   function automatic logic [31:0] sat_count(input logic [31:0] c);
      // Zero and one both mean a single arm; values clip at the top
      if (c <= tas_pkg::CNT_ONE)
         sat_count = tas_pkg::CNT_ONE;
      else if (c > tas_pkg::CNT_MAX)
         sat_count = tas_pkg::CNT_MAX;
      else
         sat_count = c;
   endfunction

   function automatic logic addr_hit(input logic [31:0] a, input logic [31:0] r);
      addr_hit = (a == r);
   endfunction

   // Only sync2/sync3 feed the edge detector, never the first stage
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         sync1 <= 1'b1;
         sync2 <= 1'b1;
         sync3 <= 1'b1;
      end else if (clk_en_i) begin
         sync1 <= ext_trig_i;
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end
   assign fall_pulse = sync3 & ~sync2;

   // Writes land at the edge where the master sees pready high; read data is
   // registered one cycle earlier so that it stands together with pready
   assign wr_en   = psel_i & penable_i & pwrite_i & pready_o;
   assign rd_en   = psel_i & penable_i & ~pwrite_i & ~pready_o;
   assign sgl_cmd = wr_en & addr_hit(paddr_i, tas_pkg::CMD_ADDR) & pwdata_i[tas_pkg::CMD_SGL_BIT];
   assign rst_cmd = wr_en & addr_hit(paddr_i, tas_pkg::CMD_ADDR) & pwdata_i[tas_pkg::CMD_RST_BIT];
   assign err_set = fall_pulse & (state == tas_pkg::TAS_READ) & ~ext_trigger_hold_ctl;

   always_comb begin
      arm_now = 1'b0;
      case (arm_event_select)
         tas_pkg::ARM_ALWAYS: arm_now = 1'b1;
         tas_pkg::ARM_EXT:    arm_now = pend_ext;
         tas_pkg::ARM_SINGLE: arm_now = 1'b1;
         tas_pkg::ARM_SYNC:   arm_now = out_buf_empty_i & mem_off_or_empty_i
                                        & data_request_sync_i;
         default:             arm_now = 1'b0;       // hold
      endcase
   end

   always_comb begin
      next_state                = state;
      next_arm_event_select     = arm_event_select;
      next_arms_left            = arms_left;
      next_arm_cnt              = arm_cnt;
      next_ext_trigger_hold_ctl = ext_trigger_hold_ctl;
      next_stored               = stored;
      next_err                  = err;
      next_pend_ext             = pend_ext;
      next_start                = 1'b0;
      next_ext_ev               = 1'b0;
      next_pready               = psel_i & penable_i & ~pready_o;
      next_prdata               = 32'h0000_0000;

      // External edges: during a reading buffer or flag, else pending
      if (fall_pulse) begin
         if (state == tas_pkg::TAS_READ) begin
            if (ext_trigger_hold_ctl) begin
               if (!stored)
                  next_stored = 1'b1;
            end else begin
               next_err = 1'b1;
            end
         end else begin
            next_pend_ext = 1'b1;
            next_ext_ev   = 1'b1;
         end
      end

      case (state)
         tas_pkg::TAS_IDLE: begin
            if (arm_now) begin
               next_state = tas_pkg::TAS_ARMED;
               if (arm_event_select == tas_pkg::ARM_EXT)
                  next_pend_ext = 1'b0;
               if (arm_event_select == tas_pkg::ARM_SINGLE) begin
                  if (arms_left <= tas_pkg::CNT_ONE) begin
                     next_arm_event_select = tas_pkg::ARM_HOLD;
                     next_arms_left        = 32'h0000_0000;
                  end else begin
                     next_arms_left = arms_left - tas_pkg::CNT_ONE;
                  end
               end
            end
         end
         tas_pkg::TAS_ARMED: begin
            if (trig_event_i)
               next_state = tas_pkg::TAS_TRIG;
         end
         tas_pkg::TAS_TRIG: begin
            if (sample_event_i) begin
               next_state = tas_pkg::TAS_READ;
               next_start = 1'b1;
            end
         end
         tas_pkg::TAS_READ: begin
            if (reading_done_i) begin
               next_state = tas_pkg::TAS_IDLE;
               if (stored || (fall_pulse && ext_trigger_hold_ctl)) begin
                  next_stored   = 1'b0;
                  next_pend_ext = 1'b1;
                  next_ext_ev   = 1'b1;
               end
            end
         end
         default: next_state = tas_pkg::TAS_IDLE;
      endcase

      if (wr_en && addr_hit(paddr_i, tas_pkg::ARM_SEL_ADDR)) begin
         if (pwdata_i[2:0] == tas_pkg::ARM_NONE || pwdata_i[2:0] > tas_pkg::ARM_SYNC)
            next_arm_event_select = tas_pkg::ARM_ALWAYS;
         else
            next_arm_event_select = pwdata_i[2:0];
         if (pwdata_i[2:0] == tas_pkg::ARM_EXT && ext_trigger_hold_ctl) begin
            next_stored   = 1'b0;
            next_pend_ext = 1'b0;
         end
         if (pwdata_i[2:0] == tas_pkg::ARM_SINGLE)
            next_arms_left = sat_count(arm_cnt);
      end
      if (wr_en && addr_hit(paddr_i, tas_pkg::ARM_CNT_ADDR))
         next_arm_cnt = pwdata_i;
      if (sgl_cmd) begin
         next_arm_event_select = tas_pkg::ARM_SINGLE;
         next_arms_left        = sat_count(arm_cnt);
      end
      if (wr_en && addr_hit(paddr_i, tas_pkg::BUF_CTL_ADDR)) begin
         next_ext_trigger_hold_ctl = pwdata_i[0];
         if (pwdata_i[0]) begin
            next_stored = 1'b0;
            if (!err_set)
               next_err = 1'b0;  // A new error in the same cycle still wins
         end
      end
      // Status error clears on write of one, but a new error wins
      if (wr_en && addr_hit(paddr_i, tas_pkg::STATUS_ADDR)
          && pwdata_i[tas_pkg::ST_ERR_BIT] && !(fall_pulse && state == tas_pkg::TAS_READ
          && !ext_trigger_hold_ctl))
         next_err = 1'b0;
      if (rst_cmd) begin
         next_ext_trigger_hold_ctl = 1'b0;
         next_stored               = 1'b0;
         next_arm_event_select     = tas_pkg::ARM_ALWAYS;
      end

      if (rd_en) begin
         if (addr_hit(paddr_i, tas_pkg::ARM_SEL_ADDR))
            next_prdata = {29'h0, arm_event_select};
         else if (addr_hit(paddr_i, tas_pkg::ARM_CNT_ADDR))
            next_prdata = arm_cnt;
         else if (addr_hit(paddr_i, tas_pkg::BUF_CTL_ADDR))
            next_prdata = {31'h0, ext_trigger_hold_ctl};
         else if (addr_hit(paddr_i, tas_pkg::STATUS_ADDR)) begin
            next_prdata[tas_pkg::ST_ARMED_BIT]  = (state != tas_pkg::TAS_IDLE);
            next_prdata[tas_pkg::ST_PEND_BIT]   = pend_ext;
            next_prdata[tas_pkg::ST_ERR_BIT]    = err;
            next_prdata[tas_pkg::ST_BUSY_BIT]   = (arms_left > tas_pkg::CNT_ONE);
            next_prdata[tas_pkg::ST_STORED_BIT] = stored;
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         state                 <= tas_pkg::TAS_IDLE;
         arm_event_select      <= tas_pkg::ARM_ALWAYS;
         arms_left             <= 32'h0000_0000;
         arm_cnt               <= tas_pkg::CNT_ONE;
         ext_trigger_hold_ctl  <= 1'b0;
         stored                <= 1'b0;
         err                   <= 1'b0;
         pend_ext              <= 1'b0;
         prdata_o              <= 32'h0000_0000;
         pready_o              <= 1'b0;
         pslverr_o             <= 1'b0;
         trig_enable_o         <= 1'b0;
         reading_start_o       <= 1'b0;
         ext_event_o           <= 1'b0;
         early_trigger_error_o <= 1'b0;
         bus_hold_o            <= 1'b0;
         reading_busy_o        <= 1'b0;
      end else if (clk_en_i) begin
         state                 <= next_state;
         arm_event_select      <= next_arm_event_select;
         arms_left             <= next_arms_left;
         arm_cnt               <= next_arm_cnt;
         ext_trigger_hold_ctl  <= next_ext_trigger_hold_ctl;
         stored                <= next_stored;
         err                   <= next_err;
         pend_ext              <= next_pend_ext;
         prdata_o              <= next_prdata;
         pready_o              <= next_pready;
         pslverr_o             <= 1'b0;
         trig_enable_o         <= (next_state == tas_pkg::TAS_TRIG);
         reading_start_o       <= next_start;
         ext_event_o           <= next_ext_ev;
         early_trigger_error_o <= next_err;
         // Busy while a multiple-arm run is left or its last cycle runs
         bus_hold_o            <= (next_arms_left > tas_pkg::CNT_ONE)
                                  || (arm_cnt > tas_pkg::CNT_ONE
                                  && next_arm_event_select == tas_pkg::ARM_SINGLE
                                  && next_arms_left == tas_pkg::CNT_ONE)
                                  || (arm_cnt > tas_pkg::CNT_ONE && next_state != tas_pkg::TAS_IDLE
                                  && next_arm_event_select == tas_pkg::ARM_HOLD);
         reading_busy_o        <= (next_state == tas_pkg::TAS_READ);
      end
   end

   a_hold_after_single: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (clk_en_i && state == tas_pkg::TAS_IDLE && arm_event_select == tas_pkg::ARM_SINGLE
       && arms_left <= tas_pkg::CNT_ONE && !wr_en)
      |=> arm_event_select == tas_pkg::ARM_HOLD)
      else $error("single arm did not fall back to hold");
   a_hold_no_arm: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (clk_en_i && state == tas_pkg::TAS_IDLE && arm_event_select == tas_pkg::ARM_HOLD)
      |=> state == tas_pkg::TAS_IDLE)
      else $error("armed while hold selected");
   a_edge_one_pulse: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (clk_en_i && fall_pulse) |=> !fall_pulse)
      else $error("edge gave a long pulse");
   a_err_when_off: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (clk_en_i && fall_pulse && state == tas_pkg::TAS_READ && !ext_trigger_hold_ctl)
      |=> err)
      else $error("early trigger not flagged");
   a_store_when_on: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (clk_en_i && fall_pulse && state == tas_pkg::TAS_READ && ext_trigger_hold_ctl
       && !reading_done_i && !wr_en) |=> stored)
      else $error("early trigger not stored");
   a_start_after_trig: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      $rose(reading_start_o) |-> $past(state) == tas_pkg::TAS_TRIG)
      else $error("reading started without trigger enable");
   a_sync_cond: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (clk_en_i && state == tas_pkg::TAS_IDLE && arm_event_select == tas_pkg::ARM_SYNC
       && !data_request_sync_i) |=> state == tas_pkg::TAS_IDLE)
      else $error("sync arm without data request");
   a_buf_readback: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (clk_en_i && rd_en && addr_hit(paddr_i, tas_pkg::BUF_CTL_ADDR))
      |=> prdata_o[0] == $past(ext_trigger_hold_ctl) && pready_o)
      else $error("buffer readback wrong");
   a_sel_fallback: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (clk_en_i && wr_en && addr_hit(paddr_i, tas_pkg::ARM_SEL_ADDR)
       && (pwdata_i[2:0] == tas_pkg::ARM_NONE || pwdata_i[2:0] > tas_pkg::ARM_SYNC))
      |=> arm_event_select == tas_pkg::ARM_ALWAYS)
      else $error("unknown arm code not mapped to always");
   a_ext_sel_clear: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (clk_en_i && wr_en && addr_hit(paddr_i, tas_pkg::ARM_SEL_ADDR)
       && pwdata_i[2:0] == tas_pkg::ARM_EXT && ext_trigger_hold_ctl) |=> !stored)
      else $error("external select left a stored trigger");
   a_buf_on_clear: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (clk_en_i && wr_en && addr_hit(paddr_i, tas_pkg::BUF_CTL_ADDR) && pwdata_i[0]
       && !err_set) |=> !stored && !err)
      else $error("buffer on did not clear buffer and error");
   a_rst_cmd_off: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (clk_en_i && rst_cmd)
      |=> !ext_trigger_hold_ctl && arm_event_select == tas_pkg::ARM_ALWAYS)
      else $error("reset command left buffering or selection");
   a_multi_busy: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (clk_en_i && state == tas_pkg::TAS_IDLE && arm_event_select == tas_pkg::ARM_SINGLE
       && arms_left > tas_pkg::CNT_ONE && arm_cnt > tas_pkg::CNT_ONE && !wr_en)
      |=> bus_hold_o)
      else $error("bus not held during multiple arming");
endmodule

// ==== sim/tas_far_model.sv ====
// Far side model: external trigger source and trigger/sample/reading stages
`timescale 1ns/1ns
module tas_far_model (
   input  wire logic core_clk_i,
   input  wire logic rst_n_i,
   input  wire logic trig_enable_i,
   input  wire logic reading_start_i,
   input  wire logic fire_i,
   input  wire logic slow_i,
   output logic      ext_trig_o,
   output logic      trig_event_o,
   output logic      sample_event_o,
   output logic      reading_done_o
);
   logic [2:0] ext_low;
   logic [7:0] rd_left;
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         ext_low        <= 3'h0;
         rd_left        <= 8'h00;
         reading_done_o <= 1'b0;
      end else begin
         ext_low        <= fire_i ? 3'h4 : (ext_low != 3'h0 ? ext_low - 3'h1 : 3'h0);
         rd_left        <= reading_start_i ? (slow_i ? 8'h28 : 8'h04)
                                           : (rd_left != 8'h00 ? rd_left - 8'h01 : 8'h00);
         reading_done_o <= (rd_left == 8'h01);
      end
   end
   // Idle level of the trigger line is high, a shot pulls it low for four cycles
   assign ext_trig_o     = (ext_low == 3'h0);
   // Trigger always offered; the sequencer must only act on it once armed
   assign trig_event_o   = 1'b1;
   assign sample_event_o = trig_enable_i;
endmodule

// ==== sim/test_tas_trigger_arm.sv ====
// Self-checking testbench for the trigger arm sequencer
`timescale 1ns/1ns
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin num_errors++; \
   $display("BAD t=%0t got %h exp %h", $time, a, b); end end
module test_tas_trigger_arm;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, q;
   logic        pready, pslverr, ext_trig, obe = 1'b0, mem = 1'b0, req = 1'b0;
   logic        trig_ev, sample_ev, rd_done, trig_en, rd_start, ext_ev, err, bus_hold, busy;
   logic        fire = 1'b0, slow = 1'b0, te_q = 1'b0, qe;
   int          num_errors = 0, checks_done = 0, rd_cnt = 0, ev_cnt = 0, n, m;
   always #4 clk = ~clk;
   tas_trigger_arm dut (.core_clk_i(clk), .rst_n_i(rst_n), .clk_en_i(1'b1), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .ext_trig_i(ext_trig),
      .out_buf_empty_i(obe), .mem_off_or_empty_i(mem), .data_request_sync_i(req),
      .trig_event_i(trig_ev), .sample_event_i(sample_ev), .reading_done_i(rd_done),
      .trig_enable_o(trig_en), .reading_start_o(rd_start), .ext_event_o(ext_ev),
      .early_trigger_error_o(err), .bus_hold_o(bus_hold), .reading_busy_o(busy));
   tas_far_model far (.core_clk_i(clk), .rst_n_i(rst_n), .trig_enable_i(trig_en),
      .reading_start_i(rd_start), .fire_i(fire), .slow_i(slow), .ext_trig_o(ext_trig),
      .trig_event_o(trig_ev), .sample_event_o(sample_ev), .reading_done_o(rd_done));
   always @(posedge clk) begin
      if (rd_start === 1'b1) begin
         rd_cnt++;
         `CHK(te_q, 1'b1)
      end
      if (ext_ev === 1'b1) ev_cnt++;
      te_q <= trig_en;
   end
   task automatic finish_test();
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
      int k;
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) begin num_errors++; finish_test(); end
      q = prdata;
      qe = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic chk_rd(input logic [31:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(q, e)
      `CHK(qe, 1'b0)
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
   endtask
   task automatic shot();
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wait_reads(input int t);
      int k;
      for (k = 0; k < 2000 && rd_cnt < t; k++) @(posedge clk);
      if (rd_cnt < t) begin num_errors++; finish_test(); end
   endtask
   logic [2:0] codes [6] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h0, 3'h7};
   logic [2:0] exps  [6] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h1, 3'h1};
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk_rd(tas_pkg::ARM_SEL_ADDR, 32'h1);
      chk_rd(tas_pkg::BUF_CTL_ADDR, 32'h0);
      chk_rd(32'h0000_0040, 32'h0);
      for (int i = 0; i < 6; i++) begin
         apb(1'b1, tas_pkg::ARM_SEL_ADDR, {29'h0, codes[i]});
         chk_rd(tas_pkg::ARM_SEL_ADDR, {29'h0, exps[i]});
      end
      apb(1'b1, tas_pkg::ARM_SEL_ADDR, {29'h0, tas_pkg::ARM_HOLD});
      cyc(30); n = rd_cnt; cyc(60);
      `CHK(rd_cnt, n)
      // Multiple arming runs without sync events selected anywhere
      apb(1'b1, tas_pkg::ARM_CNT_ADDR, 32'h3);
      apb(1'b1, tas_pkg::ARM_SEL_ADDR, {29'h0, tas_pkg::ARM_SINGLE});
      wait_reads(n + 1);
      `CHK(bus_hold, 1'b1)
      wait_reads(n + 2);
      `CHK(bus_hold, 1'b1)
      wait_reads(n + 3); cyc(60);
      `CHK(rd_cnt, n + 3)
      `CHK(bus_hold, 1'b0)
      chk_rd(tas_pkg::ARM_SEL_ADDR, 32'h4);
      apb(1'b1, tas_pkg::ARM_CNT_ADDR, 32'h0);
      n = rd_cnt;
      apb(1'b1, tas_pkg::CMD_ADDR, 32'h1 << tas_pkg::CMD_SGL_BIT);
      cyc(60);
      `CHK(rd_cnt, n + 1)
      apb(1'b1, tas_pkg::ARM_SEL_ADDR, {29'h0, tas_pkg::ARM_EXT});
      n = rd_cnt; m = ev_cnt; cyc(40);
      `CHK(rd_cnt, n)
      shot(); wait_reads(n + 1); cyc(5);
      `CHK(ev_cnt, m + 1)
      slow <= 1'b1;
      n = rd_cnt; shot(); wait_reads(n + 1); shot(); cyc(80);
      `CHK(rd_cnt, n + 1)
      apb(1'b0, tas_pkg::STATUS_ADDR, 32'h0);
      `CHK(q[tas_pkg::ST_ERR_BIT], 1'b1)
      `CHK(err, 1'b1)
      apb(1'b1, tas_pkg::BUF_CTL_ADDR, 32'h1);
      apb(1'b0, tas_pkg::STATUS_ADDR, 32'h0);
      `CHK(q[tas_pkg::ST_ERR_BIT], 1'b0)
      `CHK(err, 1'b0)
      chk_rd(tas_pkg::BUF_CTL_ADDR, 32'h1);
      n = rd_cnt; m = ev_cnt; shot(); wait_reads(n + 1); shot(); cyc(10);
      apb(1'b0, tas_pkg::STATUS_ADDR, 32'h0);
      `CHK(q[tas_pkg::ST_STORED_BIT], 1'b1)
      `CHK(q[tas_pkg::ST_ERR_BIT], 1'b0)
      `CHK(busy, 1'b1)
      wait_reads(n + 2); cyc(5);
      `CHK(ev_cnt, m + 2)
      shot(); cyc(6);
      apb(1'b0, tas_pkg::STATUS_ADDR, 32'h0);
      `CHK(q[tas_pkg::ST_STORED_BIT], 1'b1)
      apb(1'b1, tas_pkg::ARM_SEL_ADDR, {29'h0, tas_pkg::ARM_EXT});
      apb(1'b0, tas_pkg::STATUS_ADDR, 32'h0);
      `CHK(q[tas_pkg::ST_STORED_BIT], 1'b0)
      apb(1'b1, tas_pkg::CMD_ADDR, 32'h1 << tas_pkg::CMD_RST_BIT);
      chk_rd(tas_pkg::BUF_CTL_ADDR, 32'h0);
      chk_rd(tas_pkg::ARM_SEL_ADDR, 32'h1);
      slow <= 1'b0;
      apb(1'b1, tas_pkg::ARM_SEL_ADDR, {29'h0, tas_pkg::ARM_SYNC});
      cyc(30); n = rd_cnt; cyc(40);
      `CHK(rd_cnt, n)
      obe <= 1'b1; mem <= 1'b1; cyc(40);
      `CHK(rd_cnt, n)
      req <= 1'b1; wait_reads(n + 1);
      req <= 1'b0;
      cyc(10);
      finish_test();
   end
endmodule
